/* core_debug_breakpoint_unit.v */
// Purpose: debug snapshot, cause record, scratch words and code breakpoints
// Assumes: core side signals are on the same clock; AHB-Lite single slave
// Notes:   reads take one wait state so a write just before is always seen
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "core_debug_defines.vh"

module core_debug_breakpoint_unit (
    input  wire        clock,
    input  wire        arst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    input  wire        debugMode,
    input  wire        debugEnter,
    input  wire [10:0] entryStatus,
    input  wire [31:0] entryPc,
    input  wire [31:0] entrySp,
    input  wire        hostRequest,
    input  wire        debugCall,
    input  wire        dataWatch,
    input  wire        resWatch,
    input  wire [7:0]  eventThread,
    input  wire [1:0]  watchIndex,
    input  wire [31:0] watchValue,
    input  wire        issueValid,
    input  wire [2:0]  issueThread,
    input  wire [31:0] issuePc,
    input  wire        cfgWrite,
    input  wire [2:0]  cfgIndex,
    input  wire [31:0] cfgWdata,
    output reg  [31:0] cfgRdata,
    output reg         breakHit,
    output reg  [7:0]  breakThread,
    output reg  [7:0]  threadStop,
    output reg  [7:0]  fetchThreadSel,
    output reg  [4:0]  fetchRegSel,
    output reg         irq
);
    // bus phase tracking
    reg        wrPend_reg;
    reg        rdPend_reg;
    reg [7:0]  addrIdx_reg;
    wire       addrPhase;
    wire       wrStrobe;
    reg [31:0] readMux;

    // software visible state
    reg [10:0] savedStatus_reg;
    reg [31:0] savedPc_reg;
    reg [31:0] savedSp_reg;
    reg [2:0]  causeCode_reg;
    reg [7:0]  causeThread_reg;
    reg [1:0]  causeIndex_reg;
    reg [31:0] causeData_reg;
    reg [7:0]  stopMask_reg;
    reg [31:0] scratch_reg [0:7];
    reg [31:0] target_reg [0:3];
    reg [7:0]  threadEn_reg [0:3];
    reg [3:0]  sense_reg;
    reg [3:0]  enable_reg;
    reg [3:0]  irqStatus_reg;
    reg [3:0]  irqMask_reg;
    reg [3:0]  irqStatus_next;

    // breakpoint evaluation
    wire [3:0] fired;
    wire       anyFired;
    reg  [1:0] lowestFired;
    integer    i;
    integer    j;

    // an address phase is taken only while the bus is ready
    assign addrPhase = hsel & htrans[1] & hready;
    assign wrStrobe = wrPend_reg;

    // AHB-Lite slave: writes zero wait, reads one wait state
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addrIdx_reg <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= `RESET_WORD;
        end else begin
            wrPend_reg <= addrPhase & hwrite;
            rdPend_reg <= addrPhase & ~hwrite;
            if (addrPhase) begin
                addrIdx_reg <= haddr[9:2];
            end
            hresp <= 1'b0; // always OKAY, unmapped reads give zero
            if (addrPhase & ~hwrite) begin
                hreadyout <= 1'b0;
            end else if (rdPend_reg) begin
                hreadyout <= 1'b1;
                hrdata <= readMux;
            end
        end
    end

    // read mux; unmapped bits read as zero, reserved bits too except saved status bit 5, which reads its captured value
    always @* begin
        readMux = `RESET_WORD;
        case (addrIdx_reg)
            `IDX_SAVED_STATUS: readMux[10:0] = savedStatus_reg;
            `IDX_SAVED_PC:     readMux = savedPc_reg;
            `IDX_SAVED_SP:     readMux = savedSp_reg;
            `IDX_FETCH_THREAD: readMux[7:0] = fetchThreadSel;
            `IDX_FETCH_REG:    readMux[4:0] = fetchRegSel;
            `IDX_CAUSE_RECORD: begin
                readMux[2:0] = causeCode_reg;
                readMux[15:8] = causeThread_reg;
                readMux[17:16] = causeIndex_reg;
            end
            `IDX_CAUSE_DATA:   readMux = causeData_reg;
            `IDX_STOP_MASK:    readMux[7:0] = stopMask_reg;
            `IDX_IRQ_STATUS:   readMux[3:0] = irqStatus_reg;
            `IDX_IRQ_MASK:     readMux[3:0] = irqMask_reg;
            default: begin
                if (addrIdx_reg[7:3] == `IDX_SCRATCH_BASE >> 3) begin
                    readMux = scratch_reg[addrIdx_reg[2:0]];
                end else if (addrIdx_reg[7:2] == `IDX_BREAK_TARGET >> 2) begin
                    readMux = target_reg[addrIdx_reg[1:0]];
                end else if (addrIdx_reg[7:2] == `IDX_BREAK_CONTROL >> 2) begin
                    readMux[23:16] = threadEn_reg[addrIdx_reg[1:0]];
                    readMux[1] = sense_reg[addrIdx_reg[1:0]];
                    readMux[0] = enable_reg[addrIdx_reg[1:0]];
                end
            end
        endcase
    end

    // one matcher per breakpoint
    genvar g;
    generate
        for (g = 0; g < `NUM_BREAKS; g = g + 1) begin : gBreak
            code_break_matcher uMatch (
                .issueValid    (issueValid & ~debugMode),
                .issuePc       (issuePc),
                .issueThread   (issueThread),
                .target        (target_reg[g]),
                .threadEnables (threadEn_reg[g]),
                .sense         (sense_reg[g]),
                .enable        (enable_reg[g]),
                .hit           (fired[g])
            );
        end
    endgenerate

    // lowest numbered breakpoint wins when several fire together
    assign anyFired = |fired;
    always @* begin
        if (fired[0]) begin
            lowestFired = 2'd0;
        end else if (fired[1]) begin
            lowestFired = 2'd1;
        end else if (fired[2]) begin
            lowestFired = 2'd2;
        end else begin
            lowestFired = 2'd3;
        end
    end

    // snapshot on debug entry; hardware capture beats a software write
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            savedStatus_reg <= 11'h000;
            savedPc_reg <= `RESET_WORD;
            savedSp_reg <= `RESET_WORD;
        end else if (debugEnter) begin
            savedStatus_reg <= entryStatus;
            savedPc_reg <= entryPc;
            savedSp_reg <= entrySp;
        end else if (wrStrobe) begin
            case (addrIdx_reg)
                `IDX_SAVED_STATUS: begin
                    // issue mode bit 8 and reserved bit 5 keep their value
                    savedStatus_reg <= (savedStatus_reg & ~`STATUS_WRITE_MASK)
                                     | (hwdata[10:0] & `STATUS_WRITE_MASK);
                end
                `IDX_SAVED_PC: savedPc_reg <= hwdata;
                `IDX_SAVED_SP: savedSp_reg <= hwdata;
                default: ;
            endcase
        end
    end

    // remote fetch operands and stop mask
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fetchThreadSel <= 8'h00;
            fetchRegSel <= 5'h00;
            stopMask_reg <= 8'h00;
        end else if (wrStrobe) begin
            case (addrIdx_reg)
                `IDX_FETCH_THREAD: fetchThreadSel <= hwdata[7:0];
                `IDX_FETCH_REG:    fetchRegSel <= hwdata[4:0];
                `IDX_STOP_MASK:    stopMask_reg <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // stopped threads are released from the cycle after debug mode is entered until the cycle after it ends
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            threadStop <= 8'h00;
        end else begin
            threadStop <= debugMode ? 8'h00 : stopMask_reg;
        end
    end

    // cause record; host outranks breakpoints, then call, data, resource
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            causeCode_reg <= `CAUSE_NONE;
            causeThread_reg <= 8'h00;
            causeIndex_reg <= 2'd0;
            causeData_reg <= `RESET_WORD;
        end else if (hostRequest) begin
            causeCode_reg <= `CAUSE_HOST;
            causeThread_reg <= 8'h00;
            causeIndex_reg <= 2'd0;
        end else if (anyFired) begin
            causeCode_reg <= `CAUSE_CODE_BREAK;
            causeThread_reg <= {5'h00, issueThread};
            causeIndex_reg <= lowestFired;
        end else if (debugCall) begin
            causeCode_reg <= `CAUSE_CALL;
            causeThread_reg <= eventThread;
            causeIndex_reg <= 2'd0;
        end else if (dataWatch) begin
            causeCode_reg <= `CAUSE_DATA_WATCH;
            causeThread_reg <= eventThread;
            causeIndex_reg <= watchIndex;
            causeData_reg <= watchValue;
        end else if (resWatch) begin
            causeCode_reg <= `CAUSE_RES_WATCH;
            causeThread_reg <= eventThread;
            causeIndex_reg <= watchIndex;
            causeData_reg <= watchValue;
        end else if (wrStrobe) begin
            case (addrIdx_reg)
                `IDX_CAUSE_RECORD: begin
                    causeCode_reg <= hwdata[2:0];
                    causeThread_reg <= hwdata[15:8];
                    causeIndex_reg <= hwdata[17:16];
                end
                `IDX_CAUSE_DATA: causeData_reg <= hwdata;
                default: ;
            endcase
        end
    end

    // scratch words; the bus write wins over a config write the same cycle
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < `NUM_SCRATCH; i = i + 1) begin
                scratch_reg[i] <= `RESET_WORD;
            end
            cfgRdata <= `RESET_WORD;
        end else begin
            if (wrStrobe && addrIdx_reg[7:3] == `IDX_SCRATCH_BASE >> 3) begin
                scratch_reg[addrIdx_reg[2:0]] <= hwdata;
            end else if (cfgWrite) begin
                scratch_reg[cfgIndex] <= cfgWdata;
            end
            cfgRdata <= scratch_reg[cfgIndex];
        end
    end

    // breakpoint targets and controls
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (j = 0; j < `NUM_BREAKS; j = j + 1) begin
                target_reg[j] <= `RESET_WORD;
                threadEn_reg[j] <= 8'h00;
            end
            sense_reg <= 4'h0;
            enable_reg <= 4'h0;
        end else if (wrStrobe) begin
            if (addrIdx_reg[7:2] == `IDX_BREAK_TARGET >> 2) begin
                target_reg[addrIdx_reg[1:0]] <= hwdata;
            end
            if (addrIdx_reg[7:2] == `IDX_BREAK_CONTROL >> 2) begin
                threadEn_reg[addrIdx_reg[1:0]] <= hwdata[23:16];
                sense_reg[addrIdx_reg[1:0]] <= hwdata[`CTRL_SENSE_BIT];
                enable_reg[addrIdx_reg[1:0]] <= hwdata[`CTRL_ENABLE_BIT];
            end
        end
    end

    // breakpoint hit goes to the core as a one-cycle debug request
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            breakHit <= 1'b0;
            breakThread <= 8'h00;
        end else begin
            breakHit <= anyFired;
            breakThread <= anyFired ? {5'h00, issueThread} : 8'h00;
        end
    end

    // sticky events: write one to clear, a new event in that cycle wins
    always @* begin
        irqStatus_next = irqStatus_reg;
        if (wrStrobe && addrIdx_reg == `IDX_IRQ_STATUS) begin
            irqStatus_next = irqStatus_next & ~hwdata[3:0];
        end
        irqStatus_next[`IRQ_BREAK_BIT] = irqStatus_next[`IRQ_BREAK_BIT] | anyFired;
        irqStatus_next[`IRQ_ENTRY_BIT] = irqStatus_next[`IRQ_ENTRY_BIT] | debugEnter;
        irqStatus_next[`IRQ_HOST_BIT] = irqStatus_next[`IRQ_HOST_BIT] | hostRequest;
        irqStatus_next[`IRQ_WATCH_BIT] = irqStatus_next[`IRQ_WATCH_BIT]
                                       | dataWatch | resWatch;
    end

    // interrupt status, mask and level output
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irqStatus_reg <= 4'h0;
            irqMask_reg <= 4'h0;
            irq <= 1'b0;
        end else begin
            irqStatus_reg <= irqStatus_next;
            if (wrStrobe && addrIdx_reg == `IDX_IRQ_MASK) begin
                irqMask_reg <= hwdata[3:0];
                irq <= |(irqStatus_next & hwdata[3:0]);
            end else begin
                irq <= |(irqStatus_next & irqMask_reg);
            end
        end
    end
endmodule // core_debug_breakpoint_unit

`default_nettype wire

/* core_debug_defines.vh */
// Purpose: constants for the per-tile debug and breakpoint unit
// Assumes: register indices are word indices, byte address = index * 4
// Notes:   included by every design file of the unit
`ifndef CORE_DEBUG_DEFINES_VH
`define CORE_DEBUG_DEFINES_VH

// register word indices
`define IDX_SAVED_STATUS     8'h10
`define IDX_SAVED_PC         8'h11
`define IDX_SAVED_SP         8'h12
`define IDX_FETCH_THREAD     8'h13
`define IDX_FETCH_REG        8'h14
`define IDX_CAUSE_RECORD     8'h15
`define IDX_CAUSE_DATA       8'h16
`define IDX_STOP_MASK        8'h18
`define IDX_SCRATCH_BASE     8'h20
`define IDX_BREAK_TARGET     8'h30
`define IDX_BREAK_CONTROL    8'h40
`define IDX_IRQ_STATUS       8'ha0
`define IDX_IRQ_MASK         8'ha1

// saved status layout
`define STATUS_WIDTH         11
`define STATUS_WRITE_MASK    11'h6df
`define STATUS_ISSUE_BIT     8

// cause record layout and codes
`define CAUSE_CODE_LSB       0
`define CAUSE_THREAD_LSB     8
`define CAUSE_INDEX_LSB      16
`define CAUSE_NONE           3'h0
`define CAUSE_HOST           3'h1
`define CAUSE_CALL           3'h2
`define CAUSE_CODE_BREAK     3'h3
`define CAUSE_DATA_WATCH     3'h4
`define CAUSE_RES_WATCH      3'h5

// breakpoint control layout
`define CTRL_ENABLE_BIT      0
`define CTRL_SENSE_BIT       1
`define CTRL_THREADS_LSB     16

// interrupt status bits
`define IRQ_BREAK_BIT        0
`define IRQ_ENTRY_BIT        1
`define IRQ_HOST_BIT         2
`define IRQ_WATCH_BIT        3
`define IRQ_WIDTH            4

// counts and reset values
`define NUM_BREAKS           4
`define NUM_SCRATCH          8
`define NUM_THREADS          8
`define RESET_WORD           32'h0000_0000

`endif

/* code_break_matcher.v */
// Purpose: one code breakpoint compare
// Assumes: pc and thread belong to the instruction issuing this cycle
// Notes:   purely combinational, registered by the parent
`timescale 1ns/100ps
`default_nettype none
`include "core_debug_defines.vh"

module code_break_matcher (
    input  wire        issueValid,
    input  wire [31:0] issuePc,
    input  wire [2:0]  issueThread,
    input  wire [31:0] target,
    input  wire [7:0]  threadEnables,
    input  wire        sense,
    input  wire        enable,
    output wire        hit
);
    wire pcEqual;

    // sense flips equal into differ
    assign pcEqual = (issuePc == target);
    assign hit = issueValid & enable & threadEnables[issueThread] & (pcEqual ^ sense);
endmodule // code_break_matcher

`default_nettype wire

/* ahb_debugger_model.sv */
// Purpose: external debugger stand-in, drives single AHB-Lite word transfers
// Assumes: the one slave's hreadyout is wired back as hready
// Notes:   address and data lines are inverted once released, never left stale
`timescale 1ns/100ps
`default_nettype none
module ahb_debugger_model (
    input  wire logic        clock,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    // idle bus at time zero, whole words only
    initial begin
        {hsel, hwrite, htrans} = 4'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'h2;
    end

    // one transfer, entered just after a rising edge; no cycle count assumed
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= w ? d : ~hwdata;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        q = hrdata;
        hwdata <= ~hwdata;
    endtask
endmodule // ahb_debugger_model
`default_nettype wire

/* core_debug_breakpoint_unit_asserts.sv */
// Purpose: port-level checks of the debug and breakpoint unit
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module core_debug_breakpoint_unit_asserts (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       debugMode,
    input wire logic       issueValid,
    input wire logic [2:0] issueThread,
    input wire logic       breakHit,
    input wire logic [7:0] breakThread,
    input wire logic [7:0] threadStop,
    input wire logic       irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // a transfer counts only when the previous one has finished
    wire taken = hsel && htrans[1] && hready;

    property p_hit_src; breakHit |-> $past(issueValid) && !$past(debugMode); endproperty
    property p_hit_thread; breakHit |-> breakThread == {5'h0, $past(issueThread)}; endproperty
    property p_thread_idle; !breakHit |-> breakThread == 8'h0; endproperty
    property p_stop_dbg; $past(debugMode) |-> threadStop == 8'h0; endproperty
    property p_quiet_dbg; debugMode [*2] |=> !breakHit; endproperty
    property p_read_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    property p_write_fast; taken && hwrite |=> hreadyout; endproperty
    property p_okay; hresp == 1'b0; endproperty

    a_hit_src: assert property (p_hit_src) else $error("hit without issue");
    a_hit_thread: assert property (p_hit_thread) else $error("hit thread wrong");
    a_thread_idle: assert property (p_thread_idle) else $error("thread not zero");
    a_stop_dbg: assert property (p_stop_dbg) else $error("stop in debug");
    a_quiet_dbg: assert property (p_quiet_dbg) else $error("hit in debug");
    a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
    a_write_fast: assert property (p_write_fast) else $error("write stalled");
    a_okay: assert property (p_okay) else $error("error response");

    // main scenarios reached
    c_hit: cover property (breakHit);
    c_read: cover property (taken && !hwrite);
    c_irq: cover property ($rose(irq));
endmodule // core_debug_breakpoint_unit_asserts

bind core_debug_breakpoint_unit core_debug_breakpoint_unit_asserts
    core_debug_breakpoint_unit_asserts_inst (
    .clock(clock), .arst_n(arst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .debugMode(debugMode),
    .issueValid(issueValid), .issueThread(issueThread), .breakHit(breakHit),
    .breakThread(breakThread), .threadStop(threadStop), .irq(irq));
`default_nettype wire

/* core_debug_breakpoint_unit_tb_top.sv */
// Purpose: self-checking bench for the debug and breakpoint unit
// Assumes: byte address = word index * 4, reads take one wait state
// Notes:   bus traffic goes through the debugger model
`timescale 1ns/100ps
`default_nettype none
module core_debug_breakpoint_unit_tb_top;
    logic        clock, arst_n, debugMode, debugEnter, hostRequest, debugCall;
    logic        dataWatch, resWatch, issueValid, cfgWrite;
    logic [10:0] entryStatus;
    logic [31:0] entryPc, entrySp, watchValue, issuePc, cfgWdata, q, d, p;
    logic [7:0]  eventThread;
    logic [1:0]  watchIndex;
    logic [2:0]  issueThread, cfgIndex;
    logic [31:0] seed = 32'h8e9c;
    wire         hsel, hwrite, hreadyout, hresp, breakHit, irq;
    wire  [31:0] haddr, hwdata, hrdata, cfgRdata;
    wire  [1:0]  htrans;
    wire  [2:0]  hsize;
    wire  [7:0]  breakThread, threadStop, fetchThreadSel;
    wire  [4:0]  fetchRegSel;
    int          nErrors = 0, cmpCount = 0, i, k;
    // register offsets with their writable bits; breakpoint cases
    logic [31:0] ra [7] = '{32'h40, 32'h44, 32'h48, 32'h4c, 32'h50, 32'h58, 32'h60};
    logic [31:0] rm [7] = '{32'h6df, '1, '1, 32'hff, 32'h1f, '1, 32'hff};
    logic [31:0] c0 [7] = '{32'hff0001, 0, 0, 32'hff0003, 32'hff0003, 32'hff0002, 32'hff0001};
    logic [31:0] cn [7] = '{32'hff0001, 32'h200001, 32'h200001, 0, 0, 0, 32'hff0001};
    // bit7 debug mode, bit6 hit, 5:4 index, bit3 pc+4, 2:0 thread
    logic [7:0]  bx [7] = '{8'h43, 8'h03, 8'h55, 8'h4f, 8'h07, 8'h0f, 8'h83};
    logic [2:0]  cc [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h1};
    logic [4:0]  cm [5] = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h0c};

    core_debug_breakpoint_unit core_debug_breakpoint_unit_inst (
        .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .debugMode(debugMode),
        .debugEnter(debugEnter), .entryStatus(entryStatus), .entryPc(entryPc),
        .entrySp(entrySp), .hostRequest(hostRequest), .debugCall(debugCall),
        .dataWatch(dataWatch), .resWatch(resWatch), .eventThread(eventThread),
        .watchIndex(watchIndex), .watchValue(watchValue), .issueValid(issueValid),
        .issueThread(issueThread), .issuePc(issuePc), .cfgWrite(cfgWrite),
        .cfgIndex(cfgIndex), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
        .breakHit(breakHit), .breakThread(breakThread), .threadStop(threadStop),
        .fetchThreadSel(fetchThreadSel), .fetchRegSel(fetchRegSel), .irq(irq));
    ahb_debugger_model ahb_debugger_model_inst (
        .clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // host leaves thread zero; host and call leave index zero
    function automatic logic [31:0] cause(input logic [2:0] c, input logic [7:0] t,
                                          input logic [1:0] x);
        return {14'h0, (c > 3'h2) ? x : 2'h0, (c == 3'h1) ? 8'h0 : t, 5'h0, c};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmpCount++;
        if (s !== e) begin
            nErrors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic [31:0] r;
        ahb_debugger_model_inst.xfer(a, 1'b1, v, r);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        ahb_debugger_model_inst.xfer(a, 1'b0, 32'h0, r);
    endtask
    // one-cycle core event pulse; always followed by a bus access
    task automatic ev(input logic [4:0] m);
        {debugEnter, hostRequest, debugCall, dataWatch, resWatch} <= m;
        @(posedge clock);
        {debugEnter, hostRequest, debugCall, dataWatch, resWatch} <= 5'h0;
    endtask
    task automatic issue(input logic [31:0] pc, input logic [2:0] t, input logic h,
                         input logic [1:0] x);
        logic [31:0] r;
        issueValid <= 1'b1;
        issuePc <= pc;
        issueThread <= t;
        @(posedge clock);
        issueValid <= 1'b0;
        issuePc <= ~pc;
        #1;
        chk({31'h0, breakHit}, {31'h0, h});
        chk({24'h0, breakThread}, h ? {29'h0, t} : 32'h0);
        @(posedge clock);
        if (h) begin
            rd(32'h54, r);
            chk(r, cause(3'h3, {5'h0, t}, x));
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // free-running core clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard, well beyond the expected few hundred cycles
    initial begin
        #200000;
        nErrors++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        {arst_n, debugMode, debugEnter, hostRequest, debugCall} = 5'h0;
        {dataWatch, resWatch, issueValid, cfgWrite} = 4'h0;
        {entryStatus, eventThread, watchIndex, issueThread, cfgIndex} = 27'h0;
        {entryPc, entrySp, watchValue, issuePc, cfgWdata} = 160'h0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        for (i = 0; i < 4; i++) begin
            rd(32'h100 + 4 * i, q);
            chk(q, 32'h0);
        end
        rd(32'h54, q);
        chk(q, 32'h0);
        $display("test reset_values done");
        // reserved bits read zero, operands reach their ports
        for (i = 0; i < 7; i++) begin
            d = rnd();
            wr(ra[i], d);
            rd(ra[i], q);
            chk(q, d & rm[i]);
            if (i == 3) chk({24'h0, fetchThreadSel}, d & 32'hff);
            if (i == 4) chk({27'h0, fetchRegSel}, d & 32'h1f);
        end
        for (i = 0; i < 16; i++) begin
            d = rnd();
            p = (i < 8) ? 32'h80 + 4 * i : (i < 12) ? 32'ha0 + 4 * i : 32'hd0 + 4 * i;
            wr(p, d);
            rd(p, q);
            chk(q, d & ((i < 12) ? 32'hffffffff : 32'h00ff0003));
        end
        wr(32'h3fc, d);
        rd(32'h3fc, q);
        chk(q, 32'h0);
        $display("test register_access done");
        d = rnd();
        p = rnd();
        entryStatus <= d[10:0];
        entryPc <= p;
        entrySp <= ~p;
        ev(5'h10);
        rd(32'h40, q);
        chk(q, {21'h0, d[10:0]});
        rd(32'h44, q);
        chk(q, p);
        rd(32'h48, q);
        chk(q, ~p);
        wr(32'h40, 32'h7ff);
        rd(32'h40, q);
        chk(q, 32'h6df | (d & 32'h120));
        $display("test snapshot done");
        // host, call, data and resource cause codes, and host beating a call in the same cycle
        for (i = 0; i < 5; i++) begin
            d = rnd();
            eventThread <= d[7:0];
            watchIndex <= d[9:8];
            watchValue <= ~d;
            ev(cm[i]);
            rd(32'h54, q);
            chk(q, cause(cc[i], d[7:0], d[9:8]));
            if (cc[i] > 3'h3) begin
                rd(32'h58, q);
                chk(q, ~d);
            end
        end
        wr(32'h280, 32'hf);
        wr(32'h284, 32'h0);
        ev(5'h08);
        rd(32'h280, q);
        chk(q, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(32'h284, 32'h4);
        rd(32'h280, q);
        chk({31'h0, irq}, 32'h1);
        wr(32'h280, 32'h4);
        rd(32'h280, q);
        chk({q[31:1], irq}, 32'h0);
        $display("test causes done");
        d = rnd();
        p = {d[31:2], 2'b00};
        for (k = 0; k < 4; k++) wr(32'hc0 + 4 * k, p);
        for (i = 0; i < 7; i++) begin
            wr(32'h100, c0[i]);
            for (k = 1; k < 4; k++) wr(32'h100 + 4 * k, cn[i]);
            debugMode <= bx[i][7];
            issue(bx[i][3] ? p + 32'h4 : p, bx[i][2:0], bx[i][6], bx[i][5:4]);
        end
        debugMode <= 1'b0;
        $display("test breakpoints done");
        d = rnd();
        wr(32'h60, d);
        rd(32'h60, q);
        chk({24'h0, threadStop}, d & 32'hff);
        debugMode <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk({24'h0, threadStop}, 32'h0);
        @(posedge clock);
        debugMode <= 1'b0;
        // scratch words are shared with the tile configuration side
        d = rnd();
        cfgWrite <= 1'b1;
        cfgIndex <= 3'h3;
        cfgWdata <= d;
        @(posedge clock);
        cfgWrite <= 1'b0;
        rd(32'h8c, q);
        chk(q, d);
        d = rnd();
        wr(32'h94, d);
        cfgIndex <= 3'h5;
        repeat (2) @(posedge clock);
        #1;
        chk(cfgRdata, d);
        $display("test stop_and_scratch done");
        end_of_test();
    end
endmodule // core_debug_breakpoint_unit_tb_top
`default_nettype wire
